// ### hw/spl_stack_unit.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - stacks grow toward lower addresses
// - pointer holds address of last item
// - any register but counter may point
// - calls, traps implicitly use register six
// - register six stack is words only
// - push decrements pointer, then writes
// - pop reads, then increments pointer
// - call pushes link, loads return, jumps
// - counter link pushes return, then jumps
// - return recovers saved link from stack
// - trap saves counter and status word
// - return copies link to counter, pops
// - trap pushes status first, counter second
// - interrupt return pops counter then status
module spl_stack_unit (
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             sys_rst,
    // command port
    input  wire logic             cmd_valid,
    input  wire spl_pkg::spl_op_t cmd_op,
    input  wire logic [2:0]       cmd_reg,
    input  wire logic             cmd_byte,
    input  wire logic [15:0]      cmd_data,
    output logic                  cmd_ready_ff,
    output logic                  cmd_done_ff,
    output logic [15:0]           cmd_rdata_ff,
    output logic                  cmd_err_ff,
    // memory port
    output logic                  mem_req_ff,
    output logic                  mem_we_ff,
    output logic                  mem_byte_ff,
    output logic [15:0]           mem_addr_ff,
    output logic [15:0]           mem_wdata_ff,
    input  wire logic             mem_ack,
    input  wire logic [15:0]      mem_rdata,
    // architectural state view
    output logic [15:0]           program_counter_reg_ff,
    output logic [15:0]           system_stack_reg_ff,
    output logic [15:0]           processor_status_word_ff
);
    import spl_pkg::*;

    typedef struct packed {
        spl_state_t  st;
        logic        ready;
        logic        done;
        logic [15:0] rdata;
        logic        err;
        logic        req;
        logic        we;
        logic        bsel;
        logic [15:0] addr;
        logic [15:0] wdata;
        logic [15:0] psw;
        logic [2:0]  ridx;
        logic [15:0] target;
        logic        step_byte;
    } spl_state_s_t;

    spl_state_s_t s_ff;
    spl_state_s_t nxt_s;

    logic                        rf_we;
    logic [2:0]                  rf_widx;
    logic [15:0]                 rf_wdata;
    logic [SPL_REG_NUM*16-1:0]   rf_all;
    logic [15:0]                 rf_rd_unused;
    logic [15:0]                 regv [SPL_REG_NUM];
    logic [15:0]                 sp6;
    logic [15:0]                 pcv;
    logic [15:0]                 step;

    ////////////////////////////////////////////////////////////////
    // general registers
    spl_regfile #(.DATA_W(16), .NUM(SPL_REG_NUM), .IDX_W(SPL_RIDX_W)) u_regs (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .wr_en(rf_we), .wr_idx(rf_widx),
        .wr_data(rf_wdata), .rd_idx(cmd_reg), .rd_data_ff(rf_rd_unused), .all_regs(rf_all)
    );
    // unpack register view
    genvar gi;
    generate
        for (gi = 0; gi < SPL_REG_NUM; gi++) begin : g_view
            assign regv[gi] = rf_all[gi*16 +: 16];
        end
    endgenerate
    assign sp6 = regv[SPL_SYS_STACK_IDX];
    assign pcv = regv[SPL_PC_IDX];
    // step size for the named pointer; register six never steps by one
    assign step = (cmd_byte && cmd_reg != SPL_SYS_STACK_IDX) ? SPL_BYTE_STEP
                                                              : SPL_WORD_STEP;

    ////////////////////////////////////////////////////////////////
    // sequencer: one register write per cycle at most
    always_comb begin
        nxt_s       = s_ff;
        nxt_s.done  = 1'b0;
        nxt_s.err   = 1'b0;
        rf_we       = 1'b0;
        rf_widx     = '0;
        rf_wdata    = '0;
        case (s_ff.st)
            SPL_ST_IDLE: begin
                if (cmd_valid && s_ff.ready) begin
                    nxt_s.ready = 1'b0;
                    nxt_s.ridx  = cmd_reg;
                    nxt_s.target = cmd_data;
                    case (cmd_op)
                        SPL_OP_PUSH: begin
                            if (cmd_reg == SPL_PC_IDX) begin
                                nxt_s.err   = 1'b1;
                                nxt_s.done  = 1'b1;
                                nxt_s.ready = 1'b1;
                            end else begin
                                // pre-decrement toward lower memory
                                rf_we    = 1'b1;
                                rf_widx  = cmd_reg;
                                rf_wdata = regv[cmd_reg] - step;
                                nxt_s.req   = 1'b1;
                                nxt_s.we    = 1'b1;
                                nxt_s.bsel  = (step == SPL_BYTE_STEP);
                                nxt_s.addr  = regv[cmd_reg] - step;
                                nxt_s.wdata = cmd_data;
                                nxt_s.st    = SPL_ST_PUSH_WR;
                            end
                        end
                        SPL_OP_POP: begin
                            if (cmd_reg == SPL_PC_IDX) begin
                                nxt_s.err   = 1'b1;
                                nxt_s.done  = 1'b1;
                                nxt_s.ready = 1'b1;
                            end else begin
                                // read at the pointer, bump it after
                                nxt_s.req       = 1'b1;
                                nxt_s.we        = 1'b0;
                                nxt_s.bsel      = (step == SPL_BYTE_STEP);
                                nxt_s.step_byte = (step == SPL_BYTE_STEP);
                                nxt_s.addr      = regv[cmd_reg];
                                nxt_s.st        = SPL_ST_POP_RD;
                            end
                        end
                        SPL_OP_CALL: begin
                            // push the old link onto the system stack
                            rf_we    = 1'b1;
                            rf_widx  = SPL_SYS_STACK_IDX;
                            rf_wdata = sp6 - SPL_WORD_STEP;
                            nxt_s.req   = 1'b1;
                            nxt_s.we    = 1'b1;
                            nxt_s.bsel  = 1'b0;
                            nxt_s.addr  = sp6 - SPL_WORD_STEP;
                            nxt_s.wdata = regv[cmd_reg];
                            nxt_s.st    = SPL_ST_CALL_WR;
                        end
                        SPL_OP_RET: begin
                            // link to counter now, then pop link
                            rf_we    = 1'b1;
                            rf_widx  = SPL_PC_IDX;
                            rf_wdata = regv[cmd_reg];
                            nxt_s.req  = 1'b1;
                            nxt_s.we   = 1'b0;
                            nxt_s.bsel = 1'b0;
                            nxt_s.addr = sp6;
                            nxt_s.st   = SPL_ST_RET_RD;
                        end
                        SPL_OP_TRAP: begin
                            // status word goes down first
                            rf_we    = 1'b1;
                            rf_widx  = SPL_SYS_STACK_IDX;
                            rf_wdata = sp6 - SPL_WORD_STEP;
                            nxt_s.req   = 1'b1;
                            nxt_s.we    = 1'b1;
                            nxt_s.bsel  = 1'b0;
                            nxt_s.addr  = sp6 - SPL_WORD_STEP;
                            nxt_s.wdata = s_ff.psw;
                            nxt_s.st    = SPL_ST_TRAP_PSW;
                        end
                        SPL_OP_RTI: begin
                            nxt_s.req  = 1'b1;
                            nxt_s.we   = 1'b0;
                            nxt_s.bsel = 1'b0;
                            nxt_s.addr = sp6;
                            nxt_s.st   = SPL_ST_RTI_PC;
                        end
                        SPL_OP_WRREG: begin
                            // direct load, e.g. to set up a pointer
                            rf_we       = 1'b1;
                            rf_widx     = cmd_reg;
                            rf_wdata    = cmd_data;
                            nxt_s.done  = 1'b1;
                            nxt_s.ready = 1'b1;
                        end
                        default: begin
                            nxt_s.err   = 1'b1;
                            nxt_s.done  = 1'b1;
                            nxt_s.ready = 1'b1;
                        end
                    endcase
                end
            end
            SPL_ST_PUSH_WR: begin
                if (mem_ack) begin
                    nxt_s.req   = 1'b0;
                    nxt_s.done  = 1'b1;
                    nxt_s.ready = 1'b1;
                    nxt_s.st    = SPL_ST_IDLE;
                end
            end
            SPL_ST_POP_RD: begin
                if (mem_ack) begin
                    rf_we    = 1'b1;
                    rf_widx  = s_ff.ridx;
                    rf_wdata = regv[s_ff.ridx] +
                               (s_ff.step_byte ? SPL_BYTE_STEP : SPL_WORD_STEP);
                    nxt_s.rdata = mem_rdata;
                    nxt_s.req   = 1'b0;
                    nxt_s.done  = 1'b1;
                    nxt_s.ready = 1'b1;
                    nxt_s.st    = SPL_ST_IDLE;
                end
            end
            SPL_ST_CALL_WR: begin
                // counter moves only after the write is acknowledged
                if (mem_ack) begin
                    // counter link: its old value is already on the stack
                    nxt_s.req = 1'b0;
                    nxt_s.we  = 1'b0;
                    nxt_s.st  = SPL_ST_TRAP_PC;                     // reuse: jump next
                    rf_we     = (s_ff.ridx != SPL_PC_IDX);
                    rf_widx   = s_ff.ridx;
                    rf_wdata  = pcv;
                end
            end
            SPL_ST_RET_RD: begin
                if (mem_ack) begin
                    rf_we    = 1'b1;
                    rf_widx  = s_ff.ridx;
                    rf_wdata = mem_rdata;
                    nxt_s.req = 1'b0;
                    nxt_s.st  = SPL_ST_RTI_PSW;                     // reuse: pop sp next
                    nxt_s.we  = 1'b1;
                end
            end
            SPL_ST_TRAP_PSW: begin
                if (mem_ack) begin
                    // counter goes below the status word
                    rf_we    = 1'b1;
                    rf_widx  = SPL_SYS_STACK_IDX;
                    rf_wdata = sp6 - SPL_WORD_STEP;
                    nxt_s.addr  = sp6 - SPL_WORD_STEP;
                    nxt_s.wdata = pcv;
                    nxt_s.we    = 1'b1;
                    nxt_s.st    = SPL_ST_TRAP_PC;
                end
            end
            SPL_ST_TRAP_PC: begin
                // trap: wait for the counter write; call: jump now
                if (!s_ff.req || mem_ack) begin
                    rf_we    = 1'b1;
                    rf_widx  = SPL_PC_IDX;
                    rf_wdata = s_ff.target;
                    nxt_s.req   = 1'b0;
                    nxt_s.done  = 1'b1;
                    nxt_s.ready = 1'b1;
                    nxt_s.st    = SPL_ST_IDLE;
                end
            end
            SPL_ST_RTI_PC: begin
                if (mem_ack) begin
                    rf_we    = 1'b1;
                    rf_widx  = SPL_PC_IDX;
                    rf_wdata = mem_rdata;
                    nxt_s.addr = s_ff.addr + SPL_WORD_STEP;
                    nxt_s.we   = 1'b0;
                    nxt_s.st   = SPL_ST_RTI_PSW;
                end
            end
            SPL_ST_RTI_PSW: begin
                // we flags a return tail: only the pointer bump is left
                if (s_ff.we || mem_ack) begin
                    rf_we    = 1'b1;
                    rf_widx  = SPL_SYS_STACK_IDX;
                    rf_wdata = s_ff.we ? sp6 + SPL_WORD_STEP
                                       : sp6 + SPL_WORD_STEP + SPL_WORD_STEP;
                    nxt_s.psw   = s_ff.we ? s_ff.psw : mem_rdata;
                    nxt_s.we    = 1'b0;
                    nxt_s.req   = 1'b0;
                    nxt_s.done  = 1'b1;
                    nxt_s.ready = 1'b1;
                    nxt_s.st    = SPL_ST_IDLE;
                end
            end
            default: begin
                nxt_s.st    = SPL_ST_IDLE;
                nxt_s.ready = 1'b1;
            end
        endcase
    end
    ////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            s_ff       <= '0;
            s_ff.st    <= SPL_ST_IDLE;
            s_ff.ready <= 1'b1;
            s_ff.psw   <= SPL_PSW_RST;
        end else begin
            s_ff <= nxt_s;
        end
    end
    ////////////////////////////////////////////////////////////////
    // outputs straight from flops; mem_we_ff is the flopped we gated by the flopped req
    assign cmd_ready_ff             = s_ff.ready;
    assign cmd_done_ff              = s_ff.done;
    assign cmd_rdata_ff             = s_ff.rdata;
    assign cmd_err_ff               = s_ff.err;
    assign mem_req_ff               = s_ff.req;
    assign mem_we_ff                = s_ff.req & s_ff.we;
    assign mem_byte_ff              = s_ff.bsel;
    assign mem_addr_ff              = s_ff.addr;
    assign mem_wdata_ff             = s_ff.wdata;
    assign program_counter_reg_ff   = pcv;
    assign system_stack_reg_ff      = sp6;
    assign processor_status_word_ff = s_ff.psw;
endmodule
`default_nettype wire

// ### hw/spl_pkg.sv
package spl_pkg;
    // machine word and register file geometry
    localparam int SPL_DATA_W    = 16;
    localparam int SPL_REG_NUM   = 8;
    localparam int SPL_RIDX_W    = 3;
    // fixed register roles
    localparam logic [2:0] SPL_SYS_STACK_IDX = 3'h6;
    localparam logic [2:0] SPL_PC_IDX        = 3'h7;
    // pointer steps
    localparam logic [15:0] SPL_WORD_STEP = 16'h0002;
    localparam logic [15:0] SPL_BYTE_STEP = 16'h0001;
    // reset values
    localparam logic [15:0] SPL_REG_RST = 16'h0000;
    localparam logic [15:0] SPL_PSW_RST = 16'h0000;
    // operation codes on the command port
    typedef enum logic [2:0] {
        SPL_OP_PUSH,
        SPL_OP_POP,
        SPL_OP_CALL,
        SPL_OP_RET,
        SPL_OP_TRAP,
        SPL_OP_RTI,
        SPL_OP_WRREG
    } spl_op_t;
    // sequencer states
    typedef enum logic [3:0] {
        SPL_ST_IDLE,
        SPL_ST_PUSH_WR,
        SPL_ST_POP_RD,
        SPL_ST_CALL_WR,
        SPL_ST_RET_RD,
        SPL_ST_TRAP_PSW,
        SPL_ST_TRAP_PC,
        SPL_ST_RTI_PC,
        SPL_ST_RTI_PSW
    } spl_state_t;
endpackage

// ### hw/spl_regfile.sv
`timescale 1ns/1ps
`default_nettype none
// eight general registers, registered read port
module spl_regfile #(
    parameter int DATA_W = 16,
    parameter int NUM    = 8,
    parameter int IDX_W  = 3
) (
    // clock and reset
    input  wire logic              clk_sys,
    input  wire logic              sys_rst,
    // write port
    input  wire logic              wr_en,
    input  wire logic [IDX_W-1:0]  wr_idx,
    input  wire logic [DATA_W-1:0] wr_data,
    // read port, data one cycle after address
    input  wire logic [IDX_W-1:0]  rd_idx,
    output var  logic [DATA_W-1:0] rd_data_ff,
    // flat view of all registers
    output logic [NUM*DATA_W-1:0]  all_regs
);
    import spl_pkg::*;
    logic [DATA_W-1:0] mem_ff [NUM];

    ////////////////////////////////////////////////////////////////
    // one flop bank per register
    genvar gi;
    generate
        for (gi = 0; gi < NUM; gi++) begin : g_reg
            always_ff @(posedge clk_sys) begin
                if (sys_rst) begin
                    mem_ff[gi] <= DATA_W'(SPL_REG_RST);
                end else if (wr_en && wr_idx == IDX_W'(gi)) begin
                    mem_ff[gi] <= wr_data;
                end
            end
            assign all_regs[gi*DATA_W +: DATA_W] = mem_ff[gi];
        end
    endgenerate

    // registered read: old value if written in the same cycle
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rd_data_ff <= '0;
        end else begin
            rd_data_ff <= mem_ff[rd_idx];
        end
    end
endmodule
`default_nettype wire

// ### tb/spl_stack_unit_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module spl_stack_unit_monitor (
    // clock and reset
    input wire logic              clk_sys,
    input wire logic              sys_rst,
    // command port
    input wire logic              cmd_valid,
    input wire spl_pkg::spl_op_t  cmd_op,
    input wire logic [2:0]        cmd_reg,
    input wire logic              cmd_byte,
    input wire logic              cmd_ready_ff,
    input wire logic              cmd_done_ff,
    input wire logic              cmd_err_ff,
    // memory port
    input wire logic              mem_req_ff,
    input wire logic              mem_we_ff,
    input wire logic              mem_byte_ff,
    input wire logic [15:0]       mem_addr_ff,
    input wire logic [15:0]       mem_wdata_ff,
    input wire logic              mem_ack,
    // architectural state
    input wire logic [15:0]       program_counter_reg_ff,
    input wire logic [15:0]       system_stack_reg_ff,
    input wire logic [15:0]       processor_status_word_ff
);
    import spl_pkg::*;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////////////////////////////
    // command acceptance, seen at the same edge as the design
    logic take;
    logic sp_push;
    assign take    = cmd_valid && cmd_ready_ff;
    assign sp_push = take && cmd_op == SPL_OP_PUSH && cmd_reg == 3'h6;
    ////////////////////////////////////////////////////////////////
    a_push_dec_write: assert property (sp_push |=> mem_req_ff && mem_we_ff
        && mem_addr_ff == $past(system_stack_reg_ff) - 16'h2)
        else $error("push addr");
    a_sys_word_step: assert property (sp_push && cmd_byte |=> !mem_byte_ff
        && system_stack_reg_ff == $past(system_stack_reg_ff) - 16'h2)
        else $error("system stack stepped as byte");
    a_pop_read_top: assert property (take && cmd_op == SPL_OP_POP && cmd_reg == 3'h6
        |=> mem_req_ff && !mem_we_ff && mem_addr_ff == $past(system_stack_reg_ff))
        else $error("pop not read at pointer");
    a_pc_ptr_refused: assert property (take && cmd_reg == 3'h7
        && cmd_op inside {SPL_OP_PUSH, SPL_OP_POP} |=> cmd_done_ff && cmd_err_ff && !mem_req_ff)
        else $error("counter used as pointer");
    a_trap_status_first: assert property (take && cmd_op == SPL_OP_TRAP |=> mem_we_ff
        && mem_addr_ff == $past(system_stack_reg_ff) - 16'h2
        && mem_wdata_ff == $past(processor_status_word_ff))
        else $error("trap did not push status first");
    a_rti_pc_first: assert property (take && cmd_op == SPL_OP_RTI
        |=> mem_req_ff && !mem_we_ff && mem_addr_ff == $past(system_stack_reg_ff))
        else $error("rti addr");
    a_call_pc_link: assert property (take && cmd_op == SPL_OP_CALL && cmd_reg == 3'h7
        |=> mem_we_ff && mem_wdata_ff == $past(program_counter_reg_ff)
        && mem_addr_ff == $past(system_stack_reg_ff) - 16'h2)
        else $error("call link");
    a_write_holds_pc: assert property (mem_req_ff && mem_we_ff && !mem_ack
        |=> $stable(program_counter_reg_ff))
        else $error("pc moved");
    a_req_holds: assert property (mem_req_ff && !mem_ack
        |=> mem_req_ff && $stable(mem_addr_ff) && $stable(mem_we_ff))
        else $error("memory request dropped early");
    // main scenarios reached
    c_trap: cover property (take && cmd_op == SPL_OP_TRAP);
    c_rti: cover property (take && cmd_op == SPL_OP_RTI);
    c_call: cover property (take && cmd_op == SPL_OP_CALL);
endmodule
bind spl_stack_unit spl_stack_unit_monitor i_mon (.clk_sys, .sys_rst, .cmd_valid, .cmd_op,
    .cmd_reg, .cmd_byte, .cmd_ready_ff, .cmd_done_ff, .cmd_err_ff, .mem_req_ff, .mem_we_ff,
    .mem_byte_ff, .mem_addr_ff, .mem_wdata_ff, .mem_ack, .program_counter_reg_ff,
    .system_stack_reg_ff, .processor_status_word_ff);
`default_nettype wire

// ### tb/spl_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module spl_mem_model (
    // clock and reset
    input wire logic         clk_sys,
    input wire logic         sys_rst,
    // request side
    input wire logic         req,
    input wire logic         we,
    input wire logic         byte_en,
    input wire logic [15:0]  addr,
    input wire logic [15:0]  wdata,
    // wait states before each answer
    input wire logic [1:0]   lat,
    // answer side
    output var logic         ack,
    output var logic [15:0]  rdata
);
    logic [7:0] mem [0:65535];
    logic [1:0] cnt;
    initial ack = 1'b0;
    initial rdata = 16'h5a5a;
    // one-cycle ack after lat waits; data bus toggles except when answering a read
    always @(posedge clk_sys) begin
        ack <= 1'b0;
        rdata <= ~rdata;
        if (sys_rst) begin
            cnt <= 2'h0;
        end else if (req && !ack) begin
            if (cnt < lat) begin
                cnt <= cnt + 2'h1;
            end else begin
                cnt <= 2'h0;
                ack <= 1'b1;
                if (we && byte_en) mem[addr] <= addr[0] ? wdata[15:8] : wdata[7:0];
                else if (we) {mem[addr | 16'h1], mem[addr & 16'hfffe]} <= wdata;
                else if (byte_en) rdata <= {2{mem[addr]}};
                else rdata <= {mem[addr | 16'h1], mem[addr & 16'hfffe]};
            end
        end
    end
endmodule
`default_nettype wire

// ### tb/spl_stack_unit_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module spl_stack_unit_tb_top;
    import spl_pkg::*;
    logic        clk_sys = 1'b0;
    logic        sys_rst = 1'b1;
    logic        cmd_valid, cmd_byte, cmd_ready_ff, cmd_done_ff, cmd_err_ff;
    spl_op_t     cmd_op;
    logic [2:0]  cmd_reg;
    logic [15:0] cmd_data, cmd_rdata_ff;
    logic        mem_req_ff, mem_we_ff, mem_byte_ff, mem_ack;
    logic [15:0] mem_addr_ff, mem_wdata_ff, mem_rdata;
    logic [15:0] program_counter_reg_ff, system_stack_reg_ff, processor_status_word_ff;
    logic [1:0]  lat;
    logic [15:0] rf [0:7];
    logic [15:0] rd_got;
    logic        err_got;
    int          num_errors = 0;
    int          n_checks = 0;
    int          cyc = 0;
    always #12.5 clk_sys = ~clk_sys;
    ////////////////////////////////////////////////////////////////
    spl_stack_unit i_spl_stack_unit (.clk_sys, .sys_rst, .cmd_valid, .cmd_op, .cmd_reg,
        .cmd_byte, .cmd_data, .cmd_ready_ff, .cmd_done_ff, .cmd_rdata_ff, .cmd_err_ff,
        .mem_req_ff, .mem_we_ff, .mem_byte_ff, .mem_addr_ff, .mem_wdata_ff, .mem_ack,
        .mem_rdata, .program_counter_reg_ff, .system_stack_reg_ff, .processor_status_word_ff);
    spl_mem_model i_spl_mem_model (.clk_sys, .sys_rst, .req(mem_req_ff), .we(mem_we_ff),
        .byte_en(mem_byte_ff), .addr(mem_addr_ff), .wdata(mem_wdata_ff), .lat,
        .ack(mem_ack), .rdata(mem_rdata));
    ////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, seen, exp);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // pointer step: system stack always words
    function automatic logic [15:0] stp(input logic [2:0] r, input logic b);
        return (r == 3'h6 || !b) ? 16'h2 : 16'h1;
    endfunction
    // one command, valid for one clock edge only, then bounded wait for done
    task automatic do_cmd(input spl_op_t op, input logic [2:0] r, input logic b,
                          input logic [15:0] d);
        int n;
        cmd_op = op;
        cmd_reg = r;
        cmd_byte = b;
        cmd_data = d;
        cmd_valid = 1'b1;
        @(posedge clk_sys);
        #1 cmd_valid = 1'b0;
        n = 0;
        while (cmd_done_ff !== 1'b1 && n < 100) begin
            @(posedge clk_sys);
            #1 n++;
        end
        if (n == 100) check(16'h0, 16'h1, "no done");
        rd_got = cmd_rdata_ff;
        err_got = cmd_err_ff;
        @(posedge clk_sys) #1 lat = 2'($urandom_range(3, 0));
    endtask
    // hang guard
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            wrap_up();
        end
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        int i;
        logic [2:0] r, l;
        logic b;
        logic [15:0] d, e, m, pc0;
        cmd_valid = 1'b0; cmd_op = SPL_OP_WRREG; cmd_reg = 3'h0;
        cmd_byte = 1'b0; cmd_data = 16'h0; lat = 2'h0;
        void'($urandom(32'hd77e7659));
        repeat (2) @(posedge clk_sys);
        #1 sys_rst = 1'b0;
        check(program_counter_reg_ff | system_stack_reg_ff | processor_status_word_ff,
              16'h0, "reset state");
        check({15'h0, cmd_ready_ff}, 16'h1, "ready after reset");
        $display("reset test done");
        for (i = 0; i < 8; i++) begin
            rf[i] = (i == 6) ? 16'h8000 : 16'($urandom);
            do_cmd(SPL_OP_WRREG, i[2:0], 1'b0, rf[i]);
        end
        check(program_counter_reg_ff, rf[7], "pc load");
        check(system_stack_reg_ff, rf[6], "sp load");
        $display("register load test done");
        for (i = 0; i < 40; i++) begin
            r = 3'($urandom_range(6, 0));
            b = 1'($urandom);
            d = 16'($urandom);
            e = 16'($urandom);
            if (b) d = {d[7:0], d[7:0]};
            m = (stp(r, b) == 16'h1) ? 16'h00ff : 16'hffff;
            // two pushes, pointer revealed through a call on the same register, or on the counter for register six
            do_cmd(SPL_OP_PUSH, r, b, d);
            do_cmd(SPL_OP_PUSH, r, b, ~d);
            rf[r] = rf[r] - 2 * stp(r, b);
            check(system_stack_reg_ff, rf[6], "sp after push");
            l = (r == 3'h6) ? 3'h7 : r;
            pc0 = rf[7];
            do_cmd(SPL_OP_CALL, l, 1'b0, e);
            check(program_counter_reg_ff, e, "call entry");
            check(system_stack_reg_ff, rf[6] - 16'h2, "call push");
            do_cmd(SPL_OP_RET, l, 1'b0, 16'h0);
            check(program_counter_reg_ff, pc0, "return pc");
            check(system_stack_reg_ff, rf[6], "return pop");
            do_cmd(SPL_OP_CALL, l, 1'b0, e);
            do_cmd(SPL_OP_POP, 3'h6, 1'b0, 16'h0);
            check(rd_got, (l == 3'h7) ? pc0 : rf[r], "saved link");
            rf[7] = e;
            if (l != 3'h7) do_cmd(SPL_OP_WRREG, l, 1'b0, rf[l]);
            // pops come back in reverse order
            do_cmd(SPL_OP_POP, r, b, 16'h0);
            check(rd_got & m, ~d & m, "first pop");
            do_cmd(SPL_OP_POP, r, b, 16'h0);
            check(rd_got & m, d & m, "second pop");
            rf[r] = rf[r] + 2 * stp(r, b);
            check(system_stack_reg_ff, rf[6], "sp after pop");
            // interrupt return from a built frame, then a trap frame
            do_cmd(SPL_OP_PUSH, 3'h6, 1'b0, d);
            do_cmd(SPL_OP_PUSH, 3'h6, 1'b0, e);
            do_cmd(SPL_OP_RTI, 3'h0, 1'b0, 16'h0);
            check(program_counter_reg_ff, e, "rti pc");
            check(processor_status_word_ff, d, "rti status");
            check(system_stack_reg_ff, rf[6], "rti sp");
            do_cmd(SPL_OP_TRAP, 3'h0, 1'b0, ~e);
            check(program_counter_reg_ff, ~e, "trap entry");
            check(system_stack_reg_ff, rf[6] - 16'h4, "trap sp");
            do_cmd(SPL_OP_POP, 3'h6, 1'b0, 16'h0);
            check(rd_got, e, "trap pc on top");
            do_cmd(SPL_OP_POP, 3'h6, 1'b0, 16'h0);
            check(rd_got, d, "trap status below");
            rf[7] = ~e;
            // counter as pointer is refused, nothing moves
            do_cmd(i[0] ? SPL_OP_POP : SPL_OP_PUSH, 3'h7, b, d);
            check({15'h0, err_got}, 16'h1, "refused pointer");
            check(program_counter_reg_ff, rf[7], "pc untouched");
        end
        $display("random stack test done");
        wrap_up();
    end
endmodule
`default_nettype wire
